// ---- pkg/irq_front_pkg.sv ----
// Constants and carrier types shared by the interrupt pin front end.
package irq_front_pkg;

  // Number of maskable request pins and the synchroniser depth.
  localparam int NUM_REQ = 4;
  localparam int SYNC_STAGES = 2;
  // Synchronised inputs: four request pins, nmi, test, external reset.
  localparam int SYNC_W = 7;
  localparam int SY_REQ_LSB = 0;
  localparam int SY_NMI_BIT = 4;
  localparam int SY_TEST_BIT = 5;
  localparam int SY_RESN_BIT = 6;

  // Register byte offsets on the Avalon-MM slave.
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_TRIG = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_MASK = 5'h0C;
  localparam logic [4:0] OFF_STATE = 5'h10;

  // Control register fields.
  localparam int CTRL_ACK_C_BIT = 0;
  localparam int CTRL_ACK_D_BIT = 1;
  localparam int CTRL_SLAVE_BIT = 2;
  localparam int CTRL_W = 3;
  // Status and mask fields: nmi edge, request edges, wait resume.
  localparam int ST_NMI_BIT = 0;
  localparam int ST_REQ_LSB = 1;
  localparam int ST_RESUME_BIT = 5;
  localparam int STATUS_W = 6;
  // Live state register fields.
  localparam int SS_PEND_LSB = 0;
  localparam int SS_SUSP_BIT = 4;
  localparam int SS_TEST_BIT = 5;
  localparam int SS_SELECT_BIT = 6;

  // Reset values.
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] TRIG_RST = 4'h0;
  localparam logic [5:0] MASK_RST = 6'h00;

  // Interrupt type reported for the non-maskable request.
  localparam logic [7:0] NMI_TYPE = 8'h02;

  // Mode bits written by software.
  typedef struct packed {
    logic slave;
    logic ack_d;
    logic ack_c;
  } ctrl_t;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avl_req_t;

  // Avalon-MM answer to the master.
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avl_rsp_t;

  // Signals from the instruction sequencer.
  typedef struct packed {
    logic instr_boundary;
    logic wait_start;
    logic int_enable;
    logic ack;
    logic [1:0] ack_id;
  } cpu_in_t;

  // Signals to the instruction sequencer.
  typedef struct packed {
    logic nmi_take;
    logic [7:0] nmi_type;
    logic irq_pending;
    logic [3:0] req_active;
    logic suspend;
  } cpu_out_t;

endpackage

// ---- core/sync_chain.sv ----
// Multi-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module sync_chain #(
  parameter int WIDTH = 7,
  parameter int STAGES = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // The whole chain is one packed state word.
  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  // Fewer than two stages would leave metastability unresolved.
  if (STAGES < 2) begin : g_chk
    $error("sync_chain needs at least two stages");
  end

  // Shift the pins in; only the last stage is visible.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage[0] = d_i;
    for (int i = 1; i < STAGES; i++) begin
      nxt_st.stage[i] = st_ff.stage[i-1];
    end
  end

  // Registered chain, cleared by reset.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.stage[STAGES-1];

  // The output follows the pins exactly two edges later.
  property p_sync_delay;
    @(posedge clk_sys_i) disable iff (reset_i)
    !$past(reset_i, 2) |-> q_o == $past(d_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser delay is not two cycles");

endmodule

// ---- core/req_channel.sv ----
// One maskable request channel: edge or level, with a pending latch.
`timescale 1ns/1ps
module req_channel (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic level_mode_i,
  input wire logic req_i,
  input wire logic ack_i,
  output logic rise_o,
  output logic active_o
);

  // Previous synchronised level and the edge latch.
  typedef struct packed {
    logic prev;
    logic pend;
  } chan_st_t;

  chan_st_t st_ff;
  chan_st_t nxt_st;

  assign rise_o = req_i & ~st_ff.prev;

  assign active_o = level_mode_i ? req_i : st_ff.pend;

  // A new edge in the acknowledge cycle wins, so it is not lost.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = req_i;
    nxt_st.pend = (st_ff.pend & ~ack_i) | rise_o;
    if (clear_i) begin
      nxt_st.pend = 1'b0;
    end
  end

  // Channel state register.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // An edge latches the request unless clear is up in the same cycle.
  property p_edge_pend;
    @(posedge clk_sys_i) disable iff (reset_i)
    (rise_o && !clear_i) |=> st_ff.pend;
  endproperty
  a_edge_pend: assert property (p_edge_pend)
    else $error("rising request edge was not latched");

  // An acknowledge with no new edge drops the latch.
  property p_ack_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ack_i && !rise_o) |=> !st_ff.pend;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear the pending latch");

endmodule

// ---- core/interrupt_pin_front_end.sv ----
// Interrupt pin front end: nmi, four requests, test wait, reset out.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module interrupt_pin_front_end (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire irq_front_pkg::avl_req_t avl_req_i,
  output irq_front_pkg::avl_rsp_t avl_rsp_o,
  input wire logic reset_input_n_i,
  input wire logic nmi_i,
  input wire logic request_pin_a_i,
  input wire logic request_pin_b_i,
  input wire logic request_pin_c_i,
  input wire logic request_pin_d_i,
  output logic ack_out_c_o,
  output logic ack_out_c_oe_o,
  output logic ack_out_d_o,
  output logic ack_out_d_oe_o,
  input wire logic test_pin_i,
  output logic test_pin_o,
  output logic test_pin_oe_o,
  input wire irq_front_pkg::cpu_in_t cpu_i,
  output irq_front_pkg::cpu_out_t cpu_o,
  output logic reset_out_o,
  output logic irq_o
);
  import irq_front_pkg::*;

  // All state of the block, except the request channels and the synchroniser, in one word.
  typedef struct packed {
    logic acc;               // Bus access is in its answer cycle.
    logic [31:0] rdata;      // Read data held for the answer cycle.
    ctrl_t ctrl;             // Pin function selection.
    logic [3:0] trig;        // One means level, zero means edge.
    logic [5:0] mask;        // Interrupt enables per status bit.
    logic [5:0] status;      // Sticky events, cleared by reading.
    logic nmi_prev;          // Last synchronised nmi level.
    logic nmi_pend;          // Nmi edge waiting for a boundary.
    logic nmi_take;          // Nmi entry pulse to the sequencer.
    logic susp;              // Execution suspended by a wait.
    logic rst_out;           // Reset output level.
    logic ack_c_n;           // Acknowledge level for pin c.
    logic ack_d_n;           // Acknowledge level for pin d.
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [SYNC_W-1:0] pins_raw;    // Raw pins in synchroniser order.
  logic [SYNC_W-1:0] pins_sync;   // Pins after the synchroniser.
  logic [NUM_REQ-1:0] ch_req;     // Requests after pin reassignment.
  logic [NUM_REQ-1:0] ch_off;     // Pins not acting as requests.
  logic [NUM_REQ-1:0] ch_ack;     // Acknowledge per channel.
  logic [NUM_REQ-1:0] ch_rise;    // Request edge per channel.
  logic [NUM_REQ-1:0] ch_active;  // Request seen by the sequencer.
  logic [STATUS_W-1:0] events;    // Sticky event sources.
  logic [STATUS_W-1:0] rd_clear;  // Bits consumed by a status read.
  logic rst_int;                  // External reset, synchronised.
  logic test_sync;                // Test level, synchronised.
  logic nmi_sync;                 // Nmi level, synchronised.
  logic nmi_rise;                 // Nmi low to high edge.
  logic resume;                   // Suspension ends this cycle.
  logic bus_req;                  // Master has a request up.

  // True when a bus address selects the given register.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction

  // Read multiplexer; unmapped addresses read as zero.
  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] addr,
                                         input state_t s,
                                         input logic [NUM_REQ-1:0] act,
                                         input logic tst,
                                         input logic sel);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (reg_hit(addr, OFF_CTRL)) begin
      v[CTRL_W-1:0] = s.ctrl;
    end else if (reg_hit(addr, OFF_TRIG)) begin
      v[NUM_REQ-1:0] = s.trig;
    end else if (reg_hit(addr, OFF_STATUS)) begin
      v[STATUS_W-1:0] = s.status;
    end else if (reg_hit(addr, OFF_MASK)) begin
      v[STATUS_W-1:0] = s.mask;
    end else if (reg_hit(addr, OFF_STATE)) begin
      v[SS_PEND_LSB +: NUM_REQ] = act;
      v[SS_SUSP_BIT] = s.susp;
      v[SS_TEST_BIT] = tst;
      v[SS_SELECT_BIT] = sel;
    end
    rd_mux = v;
  endfunction

  assign pins_raw = {reset_input_n_i, test_pin_i, nmi_i, request_pin_d_i,
                     request_pin_c_i, request_pin_b_i, request_pin_a_i};

  // One chain serves every asynchronous pin.
  sync_chain #(
    .WIDTH(SYNC_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .d_i(pins_raw),
    .q_o(pins_sync)
  );

  assign test_sync = pins_sync[SY_TEST_BIT];
  assign nmi_sync = pins_sync[SY_NMI_BIT];
  // The chain clears to zero, so reset reads active until released.
  assign rst_int = ~pins_sync[SY_RESN_BIT];

  // slave mode takes pins b and d
  always_comb begin
    ch_off = '0;
    ch_off[1] = st_ff.ctrl.slave;
    ch_off[2] = st_ff.ctrl.ack_c;
    ch_off[3] = st_ff.ctrl.ack_d | st_ff.ctrl.slave;
  end
  assign ch_req = pins_sync[SY_REQ_LSB +: NUM_REQ] & ~ch_off;

  // One channel per request pin.
  for (genvar i = 0; i < NUM_REQ; i++) begin : g_ch
    assign ch_ack[i] = cpu_i.ack & (cpu_i.ack_id == 2'(i));
    req_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .clear_i(rst_int),
      .level_mode_i(st_ff.trig[i]),
      .req_i(ch_req[i]),
      .ack_i(ch_ack[i]),
      .rise_o(ch_rise[i]),
      .active_o(ch_active[i])
    );
  end

  assign nmi_rise = nmi_sync & ~st_ff.nmi_prev;
  assign resume = st_ff.susp & ~test_sync;
  assign bus_req = avl_req_i.read | avl_req_i.write;

  // Event sources feeding the sticky status bits.
  always_comb begin
    events = '0;
    events[ST_NMI_BIT] = nmi_rise;
    events[ST_REQ_LSB +: NUM_REQ] = ch_rise;
    events[ST_RESUME_BIT] = resume;
  end

  // Next state: bus slave, nmi, wait and pin drivers.
  always_comb begin
    nxt_st = st_ff;
    rd_clear = '0;
    // First cycle of an access: fetch data, answer next cycle.
    if (bus_req && !st_ff.acc) begin
      nxt_st.acc = 1'b1;
      if (avl_req_i.read) begin
        nxt_st.rdata = rd_mux(avl_req_i.address, st_ff, ch_active,
                              test_sync, pins_sync[1]);
      end
    end
    // Answer cycle: writes land and status reads consume bits.
    if (st_ff.acc) begin
      nxt_st.acc = 1'b0;
      if (avl_req_i.write && avl_req_i.byteenable[0]) begin
        if (reg_hit(avl_req_i.address, OFF_CTRL)) begin
          nxt_st.ctrl = avl_req_i.writedata[CTRL_W-1:0];
        end else if (reg_hit(avl_req_i.address, OFF_TRIG)) begin
          nxt_st.trig = avl_req_i.writedata[NUM_REQ-1:0];
        end else if (reg_hit(avl_req_i.address, OFF_MASK)) begin
          nxt_st.mask = avl_req_i.writedata[STATUS_W-1:0];
        end
      end
      // Only the bits that were returned are cleared.
      if (avl_req_i.read && reg_hit(avl_req_i.address, OFF_STATUS)) begin
        rd_clear = st_ff.rdata[STATUS_W-1:0];
      end
    end
    // A new event in the read cycle survives the clear.
    nxt_st.status = (st_ff.status & ~rd_clear) | events;

    nxt_st.nmi_prev = nmi_sync;
    nxt_st.nmi_take = cpu_i.instr_boundary & (st_ff.nmi_pend | nmi_rise);
    nxt_st.nmi_pend = (st_ff.nmi_pend | nmi_rise) & ~cpu_i.instr_boundary;

    if (cpu_i.wait_start && test_sync) begin
      nxt_st.susp = 1'b1;
    end else if (resume) begin
      nxt_st.susp = 1'b0;
    end

    nxt_st.ack_c_n = ~(st_ff.ctrl.ack_c & ch_ack[0]);
    nxt_st.ack_d_n = ~(st_ff.ctrl.ack_d & ch_ack[1]);

    nxt_st.rst_out = rst_int;

    if (rst_int) begin
      nxt_st.nmi_pend = 1'b0;
      nxt_st.nmi_take = 1'b0;
      nxt_st.susp = 1'b0;
    end
  end

  // State register; reset leaves acknowledges released.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.trig <= TRIG_RST;
      st_ff.mask <= MASK_RST;
      st_ff.rst_out <= 1'b1;
      st_ff.ack_c_n <= 1'b1;
      st_ff.ack_d_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus answer: one wait cycle, then data from the holding register.
  assign avl_rsp_o.waitrequest = bus_req & ~st_ff.acc;
  assign avl_rsp_o.readdata = st_ff.rdata;

  // Level interrupt while any unmasked sticky bit is set.
  assign irq_o = |(st_ff.status & st_ff.mask);

  assign cpu_o.nmi_take = st_ff.nmi_take;
  assign cpu_o.nmi_type = NMI_TYPE;
  assign cpu_o.irq_pending = cpu_i.int_enable & (|ch_active);
  assign cpu_o.req_active = ch_active;
  assign cpu_o.suspend = st_ff.susp;

  // Pin c drives only as an acknowledge; pin d also carries slave irq.
  assign ack_out_c_o = st_ff.ack_c_n;
  assign ack_out_c_oe_o = st_ff.ctrl.ack_c & ~st_ff.ctrl.slave;
  assign ack_out_d_o = st_ff.ctrl.slave ? (|ch_active) : st_ff.ack_d_n;
  assign ack_out_d_oe_o = st_ff.ctrl.ack_d | st_ff.ctrl.slave;

  assign test_pin_o = 1'b0;
  assign test_pin_oe_o = 1'b0;
  assign reset_out_o = st_ff.rst_out;

  // A synchronised nmi rise.
  sequence s_nmi_rise;
    !nmi_sync ##1 nmi_sync;
  endsequence

  // A rise is pending or taken on the following cycle.
  property p_nmi_latch;
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_nmi_rise ##0 !rst_int) |=> (st_ff.nmi_pend || st_ff.nmi_take);
  endproperty
  a_nmi_latch: assert property (p_nmi_latch)
    else $error("nmi rise was lost");

  // Entry happens only after a boundary.
  property p_nmi_boundary;
    @(posedge clk_sys_i) disable iff (reset_i)
    cpu_o.nmi_take |-> $past(cpu_i.instr_boundary);
  endproperty
  a_nmi_boundary: assert property (p_nmi_boundary)
    else $error("nmi taken away from a boundary");

  // A pending nmi is taken at the boundary, whatever the mask, unless the external reset is active.
  property p_nmi_nomask;
    @(posedge clk_sys_i) disable iff (reset_i)
    (st_ff.nmi_pend && cpu_i.instr_boundary && !rst_int) |=>
      (cpu_o.nmi_take && cpu_o.nmi_type == 8'h02);
  endproperty
  a_nmi_nomask: assert property (p_nmi_nomask)
    else $error("pending nmi not taken as type two");

  // Wait with test high suspends at the next edge.
  property p_wait_suspend;
    @(posedge clk_sys_i) disable iff (reset_i)
    (cpu_i.wait_start && test_sync && !rst_int) |=> cpu_o.suspend;
  endproperty
  a_wait_suspend: assert property (p_wait_suspend)
    else $error("wait with test high did not suspend");

  // Suspension lasts while test stays high, ends when it is low.
  sequence s_held_wait;
    cpu_o.suspend && test_sync && !rst_int;
  endsequence
  property p_wait_resume;
    @(posedge clk_sys_i) disable iff (reset_i)
    (cpu_o.suspend && !test_sync) |=> !cpu_o.suspend;
  endproperty
  a_wait_resume: assert property (p_wait_resume)
    else $error("suspension did not end on test low");
  property p_wait_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
    s_held_wait |=> cpu_o.suspend;
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("suspension ended while test was high");

  // Requests reach the sequencer during suspension.
  property p_irq_in_wait;
    @(posedge clk_sys_i) disable iff (reset_i)
    (cpu_o.suspend && cpu_i.int_enable && (|ch_active)) |->
      cpu_o.irq_pending;
  endproperty
  a_irq_in_wait: assert property (p_irq_in_wait)
    else $error("request blocked during suspension");

  // Reset output tracks the synchronised input one edge later.
  property p_reset_out;
    @(posedge clk_sys_i) disable iff (reset_i)
    rst_int |=> reset_out_o;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("reset output not asserted");

  // Acknowledge on pin c is low one cycle after the request ack.
  property p_ack_c;
    @(posedge clk_sys_i) disable iff (reset_i)
    (st_ff.ctrl.ack_c && cpu_i.ack && cpu_i.ack_id == 2'h0) |=>
      (!ack_out_c_o ##1 ack_out_c_o);
  endproperty
  a_ack_c: assert property (p_ack_c)
    else $error("pin c acknowledge pulse wrong");

endmodule

// ---- tb/irq_source_model.sv ----
// Model of the external requesters on the interrupt pins.
`timescale 1ns/1ps
module irq_source_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [3:0] raise_i,
  input wire logic nmi_fire_i,
  input wire logic ack_i,
  input wire logic [1:0] ack_id_i,
  output logic [3:0] req_o,
  output logic nmi_o
);
  // Request levels held by the sources.
  logic [3:0] req_ff;
  // Cycles of nmi pulse still to drive.
  logic [1:0] nmi_cnt_ff;

  // Sources raise on command and drop only when acknowledged.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      req_ff <= 4'h0;
      nmi_cnt_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ack_i && ack_id_i == 2'(i)) begin
          req_ff[i] <= 1'b0;
        end else if (raise_i[i]) begin
          req_ff[i] <= 1'b1;
        end
      end
      if (nmi_fire_i) begin
        nmi_cnt_ff <= 2'h2;
      end else if (nmi_cnt_ff != 2'h0) begin
        nmi_cnt_ff <= nmi_cnt_ff - 2'h1;
      end
    end
  end

  assign req_o = req_ff;
  assign nmi_o = (nmi_cnt_ff != 2'h0);
endmodule

// ---- tb/interrupt_pin_front_end_tb.sv ----
// Self-checking bench for the interrupt pin front end.
`timescale 1ns/1ps
module interrupt_pin_front_end_tb;
  import irq_front_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic reset_input_n_i = 1'b1;
  logic test_pin_i = 1'b0;
  logic [3:0] raise = 4'h0;
  logic nmi_fire = 1'b0;
  logic [3:0] req;
  logic nmi;
  avl_req_t bus = '0;
  avl_rsp_t rsp;
  cpu_in_t cpu = '0;
  cpu_out_t co;
  logic ack_c, ack_c_oe, ack_d, ack_d_oe, t_o, t_oe, rst_o, irq;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [3:0] trig;
  int n, k;

  // Free-running system clock.
  always #25 clk_sys_i = ~clk_sys_i;

  interrupt_pin_front_end i_interrupt_pin_front_end (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avl_req_i(bus),
    .avl_rsp_o(rsp), .reset_input_n_i(reset_input_n_i), .nmi_i(nmi),
    .request_pin_a_i(req[0]), .request_pin_b_i(req[1]),
    .request_pin_c_i(req[2]), .request_pin_d_i(req[3]),
    .ack_out_c_o(ack_c), .ack_out_c_oe_o(ack_c_oe),
    .ack_out_d_o(ack_d), .ack_out_d_oe_o(ack_d_oe),
    .test_pin_i(test_pin_i), .test_pin_o(t_o), .test_pin_oe_o(t_oe),
    .cpu_i(cpu), .cpu_o(co), .reset_out_o(rst_o), .irq_o(irq));

  irq_source_model i_irq_source_model (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .raise_i(raise),
    .nmi_fire_i(nmi_fire), .ack_i(cpu.ack), .ack_id_i(cpu.ack_id),
    .req_o(req), .nmi_o(nmi));

  // Compares a value and counts the outcome.
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Waits a number of rising edges, then settles to the low phase.
  task automatic nx(int c);
    repeat (c) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  // One Avalon access, held until waitrequest is seen low at an edge.
  task automatic acc(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    bus <= '{read: !w, write: w, address: a, writedata: d,
             byteenable: 4'hF};
    // Waitrequest and read data are both taken at the same rising edge.
    do @(posedge clk_sys_i); while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    bus <= '0;
    // Settle so that callers see what the write has just changed.
    @(negedge clk_sys_i);
  endtask

  // Drives one sequencer pulse; the sampling edge has passed on return.
  task automatic pulse(int f, logic [1:0] id);
    @(posedge clk_sys_i);
    cpu.instr_boundary <= (f == 0);
    cpu.wait_start <= (f == 1);
    cpu.ack <= (f == 2);
    cpu.ack_id <= id;
    @(posedge clk_sys_i);
    cpu.instr_boundary <= 1'b0;
    cpu.wait_start <= 1'b0;
    cpu.ack <= 1'b0;
    @(negedge clk_sys_i);
  endtask

  // Expected status word built from the events a scenario has caused.
  function automatic logic [31:0] exp_status(input logic nmi_ev,
      input logic [3:0] rises, input logic resumed);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[ST_NMI_BIT] = nmi_ev;
    v[ST_REQ_LSB +: NUM_REQ] = rises;
    v[ST_RESUME_BIT] = resumed;
    return v;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h006A));
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    nx(5);
    chk("test_oe", t_oe, 0);
    chk("test_o", t_o, 0);
    chk("reset_out", rst_o, 0);
    for (int a = 0; a <= 'h14; a += 4) begin
      acc(0, 5'(a), 0);
      chk("reset_val", rd, 0);
    end
    $display("test reset done");
    acc(1, OFF_CTRL, 32'h7);
    acc(1, OFF_MASK, 32'h0);
    @(posedge clk_sys_i) nmi_fire <= 1'b1;
    @(posedge clk_sys_i) nmi_fire <= 1'b0;
    nx(5);
    pulse(0, 0);
    chk("nmi_take", co.nmi_take, 1);
    chk("nmi_type", co.nmi_type, 2);
    nx(1);
    chk("nmi_once", co.nmi_take, 0);
    acc(1, OFF_CTRL, 32'h0);
    $display("test nmi done");
    trig = 4'($urandom());
    acc(1, OFF_TRIG, 32'(trig));
    @(posedge clk_sys_i) cpu.int_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) raise[i] <= 1'b1;
      @(posedge clk_sys_i) raise[i] <= 1'b0;
      nx(1);
      chk("sync_delay", co.req_active[i], 0);
      // A level request shows one edge before the edge latch does.
      nx(1);
      chk("trig_mode", co.req_active[i], trig[i]);
      nx(3);
      chk("req_active", co.req_active[i], 1);
      chk("irq_pending", co.irq_pending, 1);
      pulse(2, 2'(i));
      nx(3);
      chk("req_cleared", co.req_active[i], 0);
    end
    $display("test requests done");
    chk("irq_masked", irq, 0);
    acc(1, OFF_MASK, 32'h3F);
    nx(1);
    chk("irq_level", irq, 1);
    acc(0, OFF_STATUS, 0);
    chk("status", rd, exp_status(1'b1, 4'hF, 1'b0));
    nx(1);
    chk("irq_clear", irq, 0);
    acc(1, 5'h14, 32'h7);
    acc(0, OFF_CTRL, 0);
    chk("unmapped_wr", rd, 0);
    $display("test status done");
    acc(1, OFF_CTRL, 32'h3);
    chk("oe_c", ack_c_oe, 1);
    chk("oe_d", ack_d_oe, 1);
    for (int i = 0; i < 2; i++) begin
      pulse(2, 2'(i));
      chk("ack_low", i ? ack_d : ack_c, 0);
      nx(1);
      chk("ack_high", i ? ack_d : ack_c, 1);
    end
    acc(1, OFF_CTRL, 32'h4);
    chk("slave_oe_c", ack_c_oe, 0);
    chk("slave_oe_d", ack_d_oe, 1);
    @(posedge clk_sys_i) raise[1] <= 1'b1;
    @(posedge clk_sys_i) raise[1] <= 1'b0;
    nx(4);
    acc(0, OFF_STATE, 0);
    chk("select", rd[SS_SELECT_BIT], 1);
    chk("b_ignored", co.req_active[1], 0);
    chk("slave_irq_d", ack_d, 0);
    pulse(2, 1);
    acc(1, OFF_CTRL, 32'h0);
    $display("test pins done");
    @(posedge clk_sys_i) test_pin_i <= 1'b1;
    nx(3);
    pulse(1, 0);
    chk("suspend", co.suspend, 1);
    @(posedge clk_sys_i) raise[0] <= 1'b1;
    @(posedge clk_sys_i) raise[0] <= 1'b0;
    nx(5);
    chk("irq_in_wait", co.irq_pending, 1);
    @(posedge clk_sys_i) test_pin_i <= 1'b0;
    nx(1);
    chk("test_sync", co.suspend, 1);
    nx(2);
    chk("resume", co.suspend, 0);
    pulse(2, 0);
    acc(0, OFF_STATUS, 0);
    chk("wait_status", rd, exp_status(1'b0, 4'h1, 1'b1));
    $display("test wait done");
    n = $urandom_range(9, 3);
    @(posedge clk_sys_i) reset_input_n_i <= 1'b0;
    k = 0;
    // Count from the first edge of the low pulse, so no high cycle is missed.
    for (int c = 0; c < 20; c++) begin
      @(posedge clk_sys_i);
      if (c == n - 1) reset_input_n_i <= 1'b1;
      @(negedge clk_sys_i);
      if (c == 2) chk("test_oe_rst", t_oe, 0);
      k += int'(rst_o === 1'b1);
    end
    chk("reset_len", 32'(k), 32'(n));
    $display("test reset out done");
    wrap_up();
  end
endmodule
